// file: design/rir_top.sv
// reset pin behaviour, interrupt detection and acknowledge strobe
`include "rir_map.svh"
`default_nettype none
module rir_top
   import rir_pkg::*;
(
   input wire logic ref_clk, // core clock, one tick per phase-one cycle in times-one mode, two in divide-by-two mode
   input wire logic nrst, // asynchronous active-low reset
   input wire logic div2_mode, // 1: divide-by-two phase clocks, 0: times-one
   input wire logic micro_proc_mode, // 1: processor mode, 0: computer mode
   input wire logic [3:0] ext_irq_lines, // active-low interrupt inputs
   input wire logic [3:0] edge_detect_select, // per line: 1 edge, 0 level
   input wire logic [3:0] irq_flag_clr, // core clears a flag, one-cycle pulse
   input wire logic fetch_boundary, // core is at an instruction fetch
   input wire logic ack_decode, // ack instruction enters decode
   input wire logic ack_read, // ack instruction enters read
   input wire logic fetch_done, // external fetch finished
   input wire logic [2:0] bus_wait_wr, // software wait-state value
   input wire logic bus_wait_we, // load wait-state value
   output logic phase_one_clock, // phase one clock out
   output logic phase_three_clock, // phase three clock out
   output logic [3:0] irq_flags, // sticky interrupt flags
   output logic [3:0] irq_take, // flags presented at a fetch boundary once boot is done
   output logic irq_ack_strobe, // active-low acknowledge
   output logic ctrl_strobe_n, // bus control strobe, high when idle
   output logic rd_wr_n, // read high / write low
   output var rir_pin_en_type pin_en, // output enables of released pins
   output var rir_fetch_type fetch // reset-vector fetch control
);
   logic [3:0] sync1_r, sync2_r, prev_r, flags_r, flags_nxt;
   logic ack_r, ctl_r, rw_r, div_r, data_en_r;
   logic [2:0] wait_r;
   logic [1:0] fetch_cnt_r;
   rir_boot_type st_r, st_nxt;
   logic in_run;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) div_r <= 1'b0;
      else div_r <= ~div_r;
   end
   assign phase_one_clock = div2_mode ? div_r : ref_clk;
   assign phase_three_clock = div2_mode ? ~div_r : ~ref_clk;

   // two-stage synchroniser, sampled each cycle; late input slips a cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_r <= `RIR_SYNC_RESET;
         sync2_r <= `RIR_SYNC_RESET;
         prev_r <= `RIR_SYNC_RESET;
      end else begin
         sync1_r <= ext_irq_lines;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   wire [3:0] det_level = ~sync2_r;
   wire [3:0] det_edge = prev_r & ~sync2_r;
   wire [3:0] detect = (edge_detect_select & det_edge) | (~edge_detect_select & det_level);
   // clear wins over a detection in the same cycle
   assign flags_nxt = (flags_r | detect) & ~irq_flag_clr;
   // re-set possible one cycle after clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) flags_r <= `RIR_FLAG_RESET;
      else flags_r <= flags_nxt;
   end
   assign irq_flags = flags_r;
   // flags reach the core only at a fetch boundary
   assign irq_take = fetch_boundary && in_run ? flags_r : 4'h0;

   // ack low from decode to read
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) ack_r <= 1'b1;
      else if (ack_decode) ack_r <= 1'b0;
      else if (ack_read) ack_r <= 1'b1;
   end
   assign irq_ack_strobe = ack_r;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) wait_r <= `RIR_RESET_WAIT_STATES;
      else if (bus_wait_we && in_run) wait_r <= bus_wait_wr;
   end

   // two reset-vector fetches; released reset starts at next edge
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         RIR_IDLE: st_nxt = RIR_FETCH;
         RIR_FETCH: st_nxt = RIR_WAIT;
         RIR_WAIT: if (fetch_done) st_nxt = (fetch_cnt_r == 2'h1) ? RIR_RUN : RIR_FETCH;
         RIR_RUN: st_nxt = RIR_RUN;
      endcase
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= RIR_IDLE;
         fetch_cnt_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         if (st_r == RIR_WAIT && fetch_done) fetch_cnt_r <= fetch_cnt_r + 2'h1;
      end
   end
   assign in_run = (st_r == RIR_RUN);
   assign fetch.fetch_req = (st_r == RIR_FETCH);
   // in processor mode boot fetches read the wait register, which still holds its reset value then
   assign fetch.wait_states = micro_proc_mode ? wait_r
                                               : `RIR_ZERO_WAIT_STATES;
   assign fetch.boot_done = in_run;

   // control strobes high in reset; data enable is held low and is cleared by reset without a clock edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctl_r <= 1'b1;
         rw_r <= 1'b1;
         data_en_r <= 1'b0;
      end else begin
         ctl_r <= ~(st_r == RIR_FETCH || st_r == RIR_WAIT);
         rw_r <= 1'b1;
         data_en_r <= 1'b0;
      end
   end
   assign ctrl_strobe_n = ctl_r;
   assign rd_wr_n = rw_r;

   assign pin_en.flags_oe = nrst & in_run;
   assign pin_en.serial_oe = nrst & in_run;
   assign pin_en.timer_oe = nrst & in_run;
   assign pin_en.data_oe = data_en_r;
   assign pin_en.addr_oe = nrst & ~(st_r == RIR_IDLE);
   assign pin_en.page_oe = nrst & ~(st_r == RIR_IDLE);

   AST_ACK_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
      ack_decode |=> !irq_ack_strobe) else $error("ack not low after decode");
   AST_ACK_HIGH: assert property (@(posedge ref_clk) disable iff (!nrst)
      ack_read && !ack_decode |=> irq_ack_strobe) else $error("ack not high after read");
   AST_CLR_WINS: assert property (@(posedge ref_clk) disable iff (!nrst)
      irq_flag_clr[0] |=> !irq_flags[0]) else $error("clear lost to detect");
   AST_LEVEL_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
      !edge_detect_select[1] && !sync2_r[1] && !irq_flag_clr[1] |=> irq_flags[1])
      else $error("level detect missed");
   AST_EDGE_SET: assert property (@(posedge ref_clk) disable iff (!nrst)
      edge_detect_select[2] && $fell(sync2_r[2]) && !irq_flag_clr[2] |=> irq_flags[2])
      else $error("edge detect missed");
   AST_BOUNDARY: assert property (@(posedge ref_clk) disable iff (!nrst)
      !fetch_boundary |-> irq_take == 4'h0) else $error("take off boundary");
   AST_WAITS: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetch.fetch_req && micro_proc_mode |-> fetch.wait_states == 3'h7)
      else $error("wrong fetch waits");
   AST_NOWAIT: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetch.fetch_req && !micro_proc_mode |-> fetch.wait_states == 3'h0)
      else $error("waits in computer mode");
   AST_FLOAT: assert property (@(posedge ref_clk) disable iff (!nrst)
      !in_run |-> !pin_en.flags_oe && !pin_en.serial_oe) else $error("pins driven early");
   AST_SYNC: assert property (@(posedge ref_clk) disable iff (!nrst)
      sync2_r == $past(sync1_r)) else $error("sync stage skipped");
   AST_DATA_FLOAT: assert property (@(posedge ref_clk) disable iff (!nrst)
      !in_run |-> !pin_en.data_oe) else $error("data bus driven in boot");
   AST_ADDR_FLOAT: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_r == RIR_IDLE |-> !pin_en.addr_oe && !pin_en.page_oe)
      else $error("address driven in reset");
   AST_CTRL_IDLE: assert property (@(posedge ref_clk) disable iff (!nrst)
      in_run && $past(in_run) |-> ctrl_strobe_n && rd_wr_n) else $error("strobe low when idle");
   AST_BOOT_WAITS: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetch.fetch_req |-> wait_r == 3'h7) else $error("wait register not at reset value");
   AST_TAKE: assert property (@(posedge ref_clk) disable iff (!nrst)
      fetch_boundary && in_run |-> irq_take == irq_flags) else $error("flags not taken");
endmodule // rir_top
`default_nettype wire

// file: design/rir_map.svh
// register-free constants for the reset and interrupt response block
`ifndef RIR_MAP_SVH
`define RIR_MAP_SVH
`define RIR_NUM_IRQ 4
`define RIR_RESET_WAIT_STATES 3'h7
`define RIR_ZERO_WAIT_STATES 3'h0
`define RIR_VECTOR_FETCHES 2'h2
`define RIR_FLAG_RESET 4'h0
`define RIR_SYNC_RESET 4'hf
`endif

// file: design/rir_pkg.sv
// types shared by the reset and interrupt response block
`default_nettype none
package rir_pkg;
   typedef enum logic [1:0] {RIR_IDLE, RIR_FETCH, RIR_WAIT, RIR_RUN} rir_boot_type;
   typedef struct packed {
      logic fetch_req;
      logic [2:0] wait_states;
      logic boot_done;
   } rir_fetch_type;
   typedef struct packed {
      logic flags_oe;
      logic serial_oe;
      logic timer_oe;
      logic data_oe;
      logic addr_oe;
      logic page_oe;
   } rir_pin_en_type;
endpackage
`default_nettype wire

// file: dv/rir_irq_src.sv
// interrupt source model driving the active-low request lines
`default_nettype none
module rir_irq_src (
   input wire logic ref_clk, // core clock
   input wire logic [3:0] fire, // start one request pulse per line
   output logic [3:0] ext_irq_lines // active-low request lines
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] a_r = 4'h0;
   logic [3:0] b_r = 4'h0;
   always_ff @(negedge ref_clk) begin
      a_r <= fire;
      b_r <= a_r;
   end
   assign ext_irq_lines = ~(a_r | b_r);
endmodule // rir_irq_src
`default_nettype wire

// file: dv/rir_tb.sv
// self-checking bench for the reset and interrupt response block
`default_nettype none
module reset_and_interrupt_response_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rir_pkg::*;
   logic ref_clk = 0, nrst = 0, dv = 0, mp = 1, fb = 0, ad = 0, ar = 0, fd = 0, bwe = 0;
   logic [3:0] fire = 0, es = 0, clr = 0, irq, flags, take;
   logic [2:0] bw = 0;
   logic ack, cs, rw, clash, p1, p3;
   logic [7:0] sd = 8'h18;
   logic [1:0] i;
   rir_pin_en_type pe;
   rir_fetch_type fe;
   int fail_count = 0, compares = 0;
   rir_irq_src src (.ref_clk(ref_clk), .fire(fire), .ext_irq_lines(irq));
   rir_top uut (.ref_clk(ref_clk), .nrst(nrst), .div2_mode(dv), .micro_proc_mode(mp),
      .ext_irq_lines(irq), .edge_detect_select(es), .irq_flag_clr(clr),
      .fetch_boundary(fb), .ack_decode(ad), .ack_read(ar), .fetch_done(fd),
      .bus_wait_wr(bw), .bus_wait_we(bwe), .phase_one_clock(p1), .phase_three_clock(p3),
      .irq_flags(flags), .irq_take(take), .irq_ack_strobe(ack), .ctrl_strobe_n(cs),
      .rd_wr_n(rw), .pin_en(pe), .fetch(fe));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (fail_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic boot(input logic mode);
      int n;
      nrst = 0;
      mp = mode;
      repeat (16) @(negedge ref_clk);
      check({2'h0, pe}, 8'h00);
      check({5'h0, ack, cs, rw}, 8'h07);
      nrst = 1;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         // wait for the wait state of each fetch: strobe low and no new request
         while ((cs !== 1'b0 || fe.fetch_req !== 1'b0) && n < 40) begin
            @(negedge ref_clk);
            n++;
         end
         check({5'h0, fe.wait_states}, mode ? 8'h07 : 8'h00);
         fb = 1;
         #1 check({4'h0, take}, 8'h00);
         fb = 0;
         fd = 1;
         @(negedge ref_clk);
         fd = 0;
      end
      check({1'b0, fe.boot_done, pe}, 8'h7b);
   endtask
   task automatic run_irqs();
      for (int t = 0; t < 10; t++) begin
         sd = lfsr(sd);
         i = sd[1:0];
         es[i] = sd[2];
         dv = sd[3];
         bw = sd[6:4];
         bwe = 1;
         fire[i] <= 1'b1;
         @(negedge ref_clk);
         fire <= 4'h0;
         bwe = 0;
         repeat (2) @(negedge ref_clk);
         check({4'h0, flags}, 8'h00);
         clash = es[i] & sd[7];
         clr[i] = clash;
         @(negedge ref_clk);
         clr = 0;
         check({4'h0, flags}, clash ? 8'h00 : 8'h01 << i);
         fb = 1;
         #1 check({4'h0, take}, clash ? 8'h00 : 8'h01 << i);
         check({6'h0, p1, p3}, dv ? {6'h0, p1, ~p1} : 8'h01);
         fb = 0;
         clr[i] = 1;
         ad = 1;
         @(negedge ref_clk);
         clr = 0;
         ad = 0;
         check({7'h0, ack}, 8'h00);
         ar = 1;
         @(negedge ref_clk);
         ar = 0;
         check({3'h0, ack, flags}, 8'h10);
      end
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      conclude();
   end
   initial begin
      boot(1'b1);
      run_irqs();
      boot(1'b0);
      run_irqs();
      conclude();
   end
endmodule // reset_and_interrupt_response_tb_top
`default_nettype wire
